// ==== design/swr_defines.vh ====
`ifndef SWR_DEFINES_VH
`define SWR_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define SWR_ADR_CTRL 8'h00
`define SWR_ADR_STAT 8'h04
`define SWR_ADR_WDT 8'h08
`define SWR_ADR_WAIT 8'h0C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define SWR_CTRL_WDT_EN 0
`define SWR_CTRL_DIV_LO 4
`define SWR_CTRL_DIV_HI 6
`define SWR_WDT_EN_RST 1'b0
`define SWR_DIV_RST 3'h6

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SWR_STAT_TO 0
`define SWR_STAT_PD 1
`define SWR_STAT_SLP 2
`define SWR_STAT_RUN 3
`define SWR_STAT_FSM_LO 4
`define SWR_STAT_FSM_HI 6
`define SWR_TO_RST 1'b1
`define SWR_PD_RST 1'b1

// ----------------------------------------
// Clock divide codes
// ----------------------------------------
`define SWR_DIV_1 3'h7
`define SWR_DIV_2 3'h6
`define SWR_DIV_4 3'h5
`define SWR_DIV_8 3'h4
`define SWR_DIV_16 3'h3
`define SWR_DIV_32 3'h2
`define SWR_DIV_64 3'h1
`define SWR_DIV_LS 3'h0

// ----------------------------------------
// Wake-up wait, in system clock periods
// ----------------------------------------
`define SWR_WAKE_HS 11'h408
`define SWR_WAKE_LS 11'h00F

`endif

// ==== design/swr_ctrl.v ====
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "swr_defines.vh"

module swr_ctrl #(
   parameter IRQ_N = 8,
   parameter LS_DIV = 10'd781,
   parameter OSC_START = 11'd16,
   parameter WDT_PRE_W = 8,
   parameter WDT_CNT_W = 8
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire sleep_instr_i,
   input wire prefetch_done_i,
   input wire watchdog_clear_instruction_i,
   input wire [IRQ_N-1:0] irq_flag_i,
   input wire [IRQ_N-1:0] irq_en_i,
   output reg core_run_o,
   output reg core_reset_o,
   output reg osc_drv_en_o,
   output reg io_hold_o,
   output reg wake_irq_o,
   output reg wake_wdt_o
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam ST_RUN = 3'b000;
   localparam ST_SLEEP = 3'b001;
   localparam ST_WAKE = 3'b010;
   localparam ST_RINIT = 3'b011;
   localparam ST_ROSC = 3'b100;

   // ----------------------------------------
   // Divider lookup
   // ----------------------------------------
   function [9:0] div_of;
      input [2:0] sel;
      begin
         case (sel)
            `SWR_DIV_1: div_of = 10'd1;
            `SWR_DIV_2: div_of = 10'd2;
            `SWR_DIV_4: div_of = 10'd4;
            `SWR_DIV_8: div_of = 10'd8;
            `SWR_DIV_16: div_of = 10'd16;
            `SWR_DIV_32: div_of = 10'd32;
            `SWR_DIV_64: div_of = 10'd64;
            default: div_of = LS_DIV;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Status word layout
   // ----------------------------------------
   function [31:0] stat_word;
      input [2:0] st;
      input to_f;
      input pd_f;
      begin
         stat_word = 32'h00000000;
         stat_word[`SWR_STAT_TO] = to_f;
         stat_word[`SWR_STAT_PD] = pd_f;
         stat_word[`SWR_STAT_SLP] = (st == ST_SLEEP);
         stat_word[`SWR_STAT_RUN] = (st == ST_RUN);
         stat_word[`SWR_STAT_FSM_HI:`SWR_STAT_FSM_LO] = st;
      end
   endfunction

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg wdt_en_r;
   reg [2:0] div_sel_r;
   reg timeout_flag_r;
   reg timeout_flag_nxt;
   reg powerdown_flag_r;
   reg powerdown_flag_nxt;
   reg irq_pend_r;
   reg [9:0] div_cnt_r;
   reg [10:0] wait_cnt_r;
   reg [WDT_PRE_W-1:0] wdt_pre_r;
   reg [WDT_CNT_W-1:0] wdt_cnt_r;
   reg wdt_clr;
   reg wake_by_irq;
   reg wake_by_wdt;
   reg core_run_nxt;
   reg core_reset_nxt;
   reg osc_drv_en_nxt;
   reg io_hold_nxt;
   wire [IRQ_N-1:0] src_wake;
   wire irq_pend;
   wire sys_tick;
   wire wdt_tick;
   wire wdt_ovf;
   wire wdt_run;
   wire [10:0] wake_target;
   wire wait_done;
   wire osc_start_done;
   wire wb_req;
   wire [9:0] div_val;

   // ----------------------------------------
   // Wake sources
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < IRQ_N; gi = gi + 1) begin : g_src
         // Own enable and flag only
         assign src_wake[gi] = irq_flag_i[gi] & irq_en_i[gi];
      end
   endgenerate

   assign irq_pend = |src_wake;

   // ----------------------------------------
   // System clock tick from divider
   // ----------------------------------------
   assign div_val = div_of(div_sel_r);
   assign sys_tick = osc_drv_en_o && (div_cnt_r == div_val - 10'd1);

   always @(posedge clk_i) begin
      if (rst_i || !osc_drv_en_o) begin
         div_cnt_r <= 10'd0;
      end else if (sys_tick) begin
         div_cnt_r <= 10'd0;
      end else begin
         div_cnt_r <= div_cnt_r + 10'd1;
      end
   end

   // ----------------------------------------
   // Watchdog
   // ----------------------------------------
   assign wdt_run = wdt_en_r && (state_r != ST_RINIT) &&
                    (state_r != ST_ROSC);
   assign wdt_tick = wdt_run && (&wdt_pre_r);
   assign wdt_ovf = wdt_tick && (&wdt_cnt_r);

   always @(posedge clk_i) begin
      if (rst_i || wdt_clr || watchdog_clear_instruction_i) begin
         wdt_pre_r <= {WDT_PRE_W{1'b0}};
         wdt_cnt_r <= {WDT_CNT_W{1'b0}};
      end else if (wdt_run) begin
         wdt_pre_r <= wdt_pre_r + {{(WDT_PRE_W-1){1'b0}}, 1'b1};
         if (wdt_tick) begin
            wdt_cnt_r <= wdt_cnt_r + {{(WDT_CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ----------------------------------------
   // Wake wait and oscillator start counts
   // ----------------------------------------
   assign wake_target = (div_sel_r == `SWR_DIV_LS) ?
                        `SWR_WAKE_LS : `SWR_WAKE_HS;
   assign wait_done = sys_tick && (wait_cnt_r == wake_target - 11'd1);
   assign osc_start_done = (wait_cnt_r == OSC_START - 11'd1);

   always @(posedge clk_i) begin
      if (rst_i || (state_r != state_nxt)) begin
         wait_cnt_r <= 11'd0;
      end else if (state_r == ST_WAKE) begin
         if (sys_tick) begin
            wait_cnt_r <= wait_cnt_r + 11'd1;
         end
      end else if (state_r == ST_ROSC) begin
         wait_cnt_r <= wait_cnt_r + 11'd1;
      end
   end

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      timeout_flag_nxt = timeout_flag_r;
      powerdown_flag_nxt = powerdown_flag_r;
      wdt_clr = 1'b0;
      wake_by_irq = 1'b0;
      wake_by_wdt = 1'b0;
      case (state_r)
         ST_RUN: begin
            if (wdt_ovf) begin
               state_nxt = ST_RINIT;
               timeout_flag_nxt = 1'b0;
            end else if (sleep_instr_i && prefetch_done_i) begin
               if (!irq_pend_r) begin
                  state_nxt = ST_SLEEP;
                  wdt_clr = 1'b1;
                  timeout_flag_nxt = 1'b1;
                  powerdown_flag_nxt = 1'b0;
               end
            end
         end
         ST_SLEEP: begin
            if (irq_pend) begin
               state_nxt = ST_WAKE;
               wdt_clr = 1'b1;
               wake_by_irq = 1'b1;
            end else if (wdt_ovf) begin
               state_nxt = ST_WAKE;
               wdt_clr = 1'b1;
               timeout_flag_nxt = 1'b0;
               wake_by_wdt = 1'b1;
            end
         end
         ST_WAKE: begin
            if (wdt_ovf) begin
               state_nxt = ST_RINIT;
               timeout_flag_nxt = 1'b0;
            end else if (wait_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_RINIT: begin
            state_nxt = ST_ROSC;
         end
         ST_ROSC: begin
            if (osc_start_done) begin
               state_nxt = ST_RUN;
            end
         end
         default: begin
            state_nxt = ST_RINIT;
         end
      endcase
   end

   // ----------------------------------------
   // Output decode from next state
   // ----------------------------------------
   always @* begin
      core_run_nxt = 1'b0;
      core_reset_nxt = 1'b0;
      osc_drv_en_nxt = 1'b1;
      io_hold_nxt = 1'b0;
      case (state_nxt)
         ST_RUN: begin
            core_run_nxt = 1'b1;
         end
         ST_SLEEP: begin
            osc_drv_en_nxt = 1'b0;
            io_hold_nxt = 1'b1;
         end
         ST_WAKE: begin
            osc_drv_en_nxt = 1'b1;
         end
         ST_RINIT: begin
            core_reset_nxt = 1'b1;
            osc_drv_en_nxt = 1'b0;
         end
         ST_ROSC: begin
            core_reset_nxt = 1'b1;
         end
         default: begin
            core_reset_nxt = 1'b1;
            osc_drv_en_nxt = 1'b0;
         end
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= ST_RINIT;
         timeout_flag_r <= `SWR_TO_RST;
         powerdown_flag_r <= `SWR_PD_RST;
         irq_pend_r <= 1'b0;
         core_run_o <= 1'b0;
         core_reset_o <= 1'b1;
         osc_drv_en_o <= 1'b0;
         io_hold_o <= 1'b0;
         wake_irq_o <= 1'b0;
         wake_wdt_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         timeout_flag_r <= timeout_flag_nxt;
         powerdown_flag_r <= powerdown_flag_nxt;
         irq_pend_r <= irq_pend;
         core_run_o <= core_run_nxt;
         core_reset_o <= core_reset_nxt;
         osc_drv_en_o <= osc_drv_en_nxt;
         io_hold_o <= io_hold_nxt;
         wake_irq_o <= wake_by_irq;
         wake_wdt_o <= wake_by_wdt;
      end
   end

   // ----------------------------------------
   // Wishbone slave
   // ----------------------------------------
   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always @(posedge clk_i) begin
      if (rst_i || (state_r == ST_RINIT)) begin
         wdt_en_r <= `SWR_WDT_EN_RST;
         div_sel_r <= `SWR_DIV_RST;
      end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                   (wb_adr_i == `SWR_ADR_CTRL)) begin
         wdt_en_r <= wb_dat_i[`SWR_CTRL_WDT_EN];
         div_sel_r <= wb_dat_i[`SWR_CTRL_DIV_HI:`SWR_CTRL_DIV_LO];
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h00000000;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               `SWR_ADR_CTRL: begin
                  wb_dat_o[`SWR_CTRL_WDT_EN] <= wdt_en_r;
                  wb_dat_o[`SWR_CTRL_DIV_HI:`SWR_CTRL_DIV_LO] <= div_sel_r;
               end
               `SWR_ADR_STAT: begin
                  wb_dat_o <= stat_word(state_r, timeout_flag_r,
                                        powerdown_flag_r);
               end
               `SWR_ADR_WDT: begin
                  wb_dat_o[WDT_CNT_W-1:0] <= wdt_cnt_r;
               end
               `SWR_ADR_WAIT: begin
                  wb_dat_o[10:0] <= wait_cnt_r;
               end
               default: begin
                  wb_dat_o <= 32'h00000000;
               end
            endcase
         end
      end
   end

endmodule // swr_ctrl

// ==== testbench/swr_ctrl_props.sv ====
`timescale 1ns/100ps
module swr_ctrl_props #(
   parameter IRQ_N = 8,
   parameter LS_DIV = 10'd781
) (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire wb_ack_o,
   input wire sleep_instr_i,
   input wire prefetch_done_i,
   input wire [IRQ_N-1:0] irq_flag_i,
   input wire [IRQ_N-1:0] irq_en_i,
   input wire core_run_o,
   input wire core_reset_o,
   input wire osc_drv_en_o,
   input wire io_hold_o,
   input wire wake_irq_o,
   input wire wake_wdt_o
);
   // ----------------------------------------
   // Tracking of control and wake wait
   // ----------------------------------------
   reg [2:0] div_r;
   reg en_r, wk_r;
   reg [17:0] cnt_r;
   int exp_w;
   wire pend = |(irq_flag_i & irq_en_i);
   wire go = core_run_o && sleep_instr_i && prefetch_done_i;
   assign exp_w = div_r == 3'h0 ? 15 * LS_DIV : 1032 << (7 - div_r);
   always @(posedge clk_i) begin
      if (core_reset_o) begin
         div_r <= 3'h6;
         en_r <= 1'b0;
      end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
                   wb_adr_i == 8'h00 && wb_sel_i[0]) begin
         div_r <= wb_dat_i[6:4];
         en_r <= wb_dat_i[0];
      end
      wk_r <= (wk_r || wake_irq_o || wake_wdt_o) && !core_run_o &&
              !core_reset_o;
      cnt_r <= wk_r ? cnt_r + 18'h1 : 18'h0;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_sleep_entry: assert property (
      go && !$past(pend) |=> io_hold_o && !osc_drv_en_o && !core_run_o)
      else $error("Sleep entry outputs wrong");
   a_need_prefetch: assert property (
      core_run_o && sleep_instr_i && !prefetch_done_i |=> !io_hold_o)
      else $error("Sleep taken without prefetch");
   a_pend_noop: assert property (
      go && $past(pend) |=> !io_hold_o)
      else $error("Sleep not a no-op");
   a_irq_wake: assert property (
      io_hold_o && pend |=> wake_irq_o && osc_drv_en_o && !io_hold_o)
      else $error("Interrupt wake missing");
   a_wdt_wake: assert property (
      $rose(io_hold_o) && en_r |-> ##[1:40] (wake_wdt_o || wake_irq_o))
      else $error("Watchdog wake missing");
   a_reset_order: assert property (
      $rose(core_reset_o) |-> (!osc_drv_en_o && !core_run_o) ##1
      (osc_drv_en_o && core_reset_o)[*3] ##[1:3] (core_run_o && !core_reset_o))
      else $error("Reset order wrong");
   a_wake_wait: assert property (
      $rose(core_run_o) && wk_r |-> cnt_r + 2 >= exp_w && cnt_r <= exp_w + 70)
      else $error("Wake wait length wrong");
   a_ack_next: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("Bus ack late");
   c_irq: cover property (wake_irq_o);
   c_wdt: cover property (wake_wdt_o);
   c_rst: cover property ($rose(core_reset_o));
endmodule // swr_ctrl_props

bind swr_ctrl swr_ctrl_props #(.IRQ_N(IRQ_N), .LS_DIV(LS_DIV)) i_swr_ctrl_props (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .sleep_instr_i(sleep_instr_i),
   .prefetch_done_i(prefetch_done_i), .irq_flag_i(irq_flag_i),
   .irq_en_i(irq_en_i), .core_run_o(core_run_o), .core_reset_o(core_reset_o),
   .osc_drv_en_o(osc_drv_en_o), .io_hold_o(io_hold_o),
   .wake_irq_o(wake_irq_o), .wake_wdt_o(wake_wdt_o));

// ==== testbench/swr_core_model.sv ====
`timescale 1ns/100ps
module swr_core_model (
   input wire clk_i,
   output reg sleep_instr_o,
   output reg prefetch_done_o,
   output reg wdt_clr_o,
   output reg [7:0] irq_flag_o,
   output reg [7:0] irq_en_o
);
   initial begin
      sleep_instr_o = 1'b0;
      prefetch_done_o = 1'b0;
      wdt_clr_o = 1'b0;
      irq_flag_o = 8'h00;
      irq_en_o = 8'h01;
   end
   // ----------------------------------------
   // Clear, sleep, then a no-op
   // ----------------------------------------
   task sleep_op(input irq_now, input pf);
      @(posedge clk_i);
      wdt_clr_o <= 1'b1;
      @(posedge clk_i);
      wdt_clr_o <= 1'b0;
      sleep_instr_o <= 1'b1;
      prefetch_done_o <= pf;
      if (irq_now) irq_flag_o <= 8'h01;
      @(posedge clk_i);
      sleep_instr_o <= 1'b0;
      prefetch_done_o <= 1'b0;
   endtask
   task set_en(input [7:0] f);
      @(posedge clk_i);
      irq_en_o <= f;
   endtask
   task set_irq(input [7:0] f);
      @(posedge clk_i);
      irq_flag_o <= f;
   endtask
endmodule // swr_core_model

// ==== testbench/swr_ctrl_bench.sv ====
`timescale 1ns/100ps
module swr_ctrl_bench;
   reg clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   reg [7:0] wb_adr_i = 0;
   reg [3:0] wb_sel_i = 0;
   reg [31:0] wb_dat_i = 0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, core_run_o, core_reset_o, osc_drv_en_o, io_hold_o;
   wire wake_irq_o, wake_wdt_o, si, pf, wc;
   wire [7:0] fl, en;
   wire [2:0] ev = {core_reset_o, wake_wdt_o, wake_irq_o};
   integer fail_count = 0, n_tests = 0;
   initial forever #20 clk_i = ~clk_i;
   swr_core_model i_swr_core_model (.clk_i(clk_i), .sleep_instr_o(si),
      .prefetch_done_o(pf), .wdt_clr_o(wc), .irq_flag_o(fl), .irq_en_o(en));
   swr_ctrl #(.IRQ_N(8), .LS_DIV(10'd4), .OSC_START(11'd4), .WDT_PRE_W(2),
      .WDT_CNT_W(3)) i_swr_ctrl (.clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sleep_instr_i(si),
      .prefetch_done_i(pf), .watchdog_clear_instruction_i(wc),
      .irq_flag_i(fl), .irq_en_i(en), .core_run_o(core_run_o),
      .core_reset_o(core_reset_o), .osc_drv_en_o(osc_drv_en_o),
      .io_hold_o(io_hold_o), .wake_irq_o(wake_irq_o), .wake_wdt_o(wake_wdt_o));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input [31:0] g, input [31:0] e);
      n_tests = n_tests + 1;
      if (g !== e) begin
         fail_count = fail_count + 1;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task wb(input w, input [3:0] s, input [7:0] a, input [31:0] d,
      output [31:0] q);
      integer n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
      wb_sel_i <= s;
      n = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20) begin
         n = n + 1;
         @(posedge clk_i);
      end
      if (n >= 20) begin
         fail_count = fail_count + 1;
         $display("Error at %0t: bus ack timeout", $time);
      end
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
   endtask
   task rd(input [7:0] a, input [31:0] e);
      reg [31:0] q;
      wb(1'b0, 4'hF, a, 32'h0, q);
      chk(q, e);
   endtask
   task wr(input [7:0] a, input [31:0] d, input [3:0] s);
      reg [31:0] q;
      wb(1'b1, s, a, d, q);
   endtask
   task wait_run(output integer n);
      n = 0;
      while (core_run_o !== 1'b1 && n < 70000) begin
         n = n + 1;
         @(posedge clk_i);
      end
      if (n >= 70000) begin
         fail_count = fail_count + 1;
         $display("Error at %0t: core never released", $time);
      end
   endtask
   task wait_sig(input integer k);
      integer n;
      n = 0;
      while (ev[k] !== 1'b1 && n < 200) begin
         n = n + 1;
         @(posedge clk_i);
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_reset;
      integer n;
      wait_run(n);
      rd(8'h00, 32'h60);
      rd(8'h04, 32'h0B);
      rd(8'h10, 32'h0);
      wr(8'h00, 32'h61, 4'hE);
      rd(8'h00, 32'h60);
   endtask
   task t_noop;
      i_swr_core_model.set_irq(8'h01);
      i_swr_core_model.sleep_op(1'b0, 1'b1);
      @(posedge clk_i);
      chk(32'(io_hold_o), 32'h0);
      rd(8'h04, 32'h0B);
      i_swr_core_model.set_irq(8'h00);
      i_swr_core_model.sleep_op(1'b0, 1'b0);
      @(posedge clk_i);
      chk(32'(io_hold_o), 32'h0);
   endtask
   task t_irq_wake(input now);
      integer n;
      i_swr_core_model.sleep_op(now, 1'b1);
      if (!now) begin
         @(posedge clk_i);
         chk(32'(io_hold_o), 32'h1);
         rd(8'h04, 32'h15);
         i_swr_core_model.set_irq(8'h02);
         repeat (5) @(posedge clk_i);
         chk(32'(io_hold_o), 32'h1);
         i_swr_core_model.set_en(8'hFD);
         repeat (3) @(posedge clk_i);
         chk(32'(io_hold_o), 32'h1);
         i_swr_core_model.set_en(8'h02);
      end
      wait_sig(0);
      chk(32'(wake_irq_o), 32'h1);
      i_swr_core_model.set_irq(8'h00);
      i_swr_core_model.set_en(8'h01);
      wait_run(n);
      rd(8'h04, 32'h09);
      rd(8'h08, 32'h0);
   endtask
   task t_wake_time(input [2:0] code, input integer e, input integer d);
      integer n;
      wr(8'h00, {25'h0, code, 4'h0}, 4'h1);
      i_swr_core_model.sleep_op(1'b0, 1'b1);
      i_swr_core_model.set_irq(8'h01);
      wait_sig(0);
      i_swr_core_model.set_irq(8'h00);
      wait_run(n);
      chk(32'(n + 4 >= e && n <= e + d + 4), 32'h1);
   endtask
   task t_wdt;
      integer n;
      wr(8'h00, 32'h61, 4'h1);
      i_swr_core_model.sleep_op(1'b0, 1'b1);
      wait_sig(1);
      chk(32'(wake_wdt_o), 32'h1);
      wait_sig(2);
      chk(32'({core_reset_o, osc_drv_en_o}), 32'h2);
      wait_run(n);
      rd(8'h00, 32'h60);
      rd(8'h04, 32'h08);
   endtask
   task summarize;
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset;
      t_noop;
      t_irq_wake(1'b0);
      t_irq_wake(1'b1);
      t_wake_time(3'h0, 60, 4);
      t_wake_time(3'h7, 1032, 1);
      t_wdt;
      summarize;
   end
   initial begin
      #600000;
      fail_count = fail_count + 1;
      summarize;
   end
endmodule // swr_ctrl_bench
